// File: logic/rot_map.svh
// Register offsets, field positions and reset values of the radio test bank
`ifndef ROT_MAP_SVH
`define ROT_MAP_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define ROT_ADDR_FORCE_A   7'h5D
`define ROT_ADDR_FORCE_B   7'h5E
`define ROT_ADDR_FORCE_C   7'h5F
`define ROT_ADDR_COEF_IDX  7'h60
`define ROT_ADDR_COEF_WORD 7'h61
`define ROT_ADDR_XTAL      7'h62
`define ROT_ADDR_RC_COARSE 7'h63

// ************************************************************
// Reset values
// ************************************************************
`define ROT_RST_FORCE_A    8'h00
`define ROT_RST_FORCE_B    8'h00
`define ROT_RST_FORCE_C    8'h00
`define ROT_RST_COEF_IDX   8'h00
`define ROT_RST_COEF_WORD  6'h00
`define ROT_RST_XTAL_WR    5'h04
`define ROT_RST_RC_COARSE  8'h00
`define ROT_RDATA_ZERO     8'h00

// ************************************************************
// Field positions
// ************************************************************
`define ROT_LDET_BIT       6
`define ROT_COEF_IDX_MSB   3
`define ROT_COEF_WORD_MSB  5
`define ROT_XTAL_WR_MSB    4
`define ROT_XTAL_HYST_BIT  4
`define ROT_XTAL_BIAS_BIT  3
`define ROT_XTAL_GAIN_BIT  2
`define ROT_XTAL_OVR_BIT   1
`define ROT_XTAL_BUF_BIT   0
`define ROT_RC_OVR_BIT     7
`define ROT_RC_VAL_MSB     6

`endif

// File: logic/rot_pkg.sv
// Types shared by the radio test bank and its users
package rot_pkg;

	// Register access request from the serial interface front end
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [6:0] addr;
		logic [7:0] wdata;
	} rot_reg_req_type;

	// Crystal oscillator controls that leave the bank
	typedef struct packed {
		logic hyst;
		logic double_bias;
		logic double_gain;
		logic buf_en;
	} rot_xtal_type;

	// Three groups of analog block enables
	typedef struct packed {
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] c;
	} rot_blk_en_type;

endpackage : rot_pkg

// File: logic/rot_regs.sv
// Analog override, filter coefficient, crystal and RC calibration test registers
//
// Functional notes
// RULE1 - Crystal register bits 7:5 read the power state: 000,001,011,010,111.
// RULE2 - Buffer override select 0: state machine drives buffer; 1: enable bit drives.
// RULE3 - Buffer enable bit does nothing unless override select is 1.
// RULE4 - Coarse RC override 0: seven-bit field reads internal calibration result.
// RULE5 - Coarse RC override 1: host writes field, device uses written value.
// RULE6 - Coefficient index bits 3:0 pick one of sixteen filter entries; 7:4 reserved.
// RULE7 - Coefficient word bits 5:0 access selected entry; 7:6 reserved; resets zero.
// RULE8 - Second enable register bit 6 drives lock detector directly, no override.
// RULE9 - First force register: mixer,LNA,PGA,PA,buf5,div3_2,buf1_2,mux2; resets zero.
// RULE10 - Second: delta-sigma, mux3, buf4, buf3, buf1_1, buf2; bit 0 PLL reset.
// RULE11 - Third: frac div, div3_1, div2, div1.5, bias shunt, VCO, CP, bandgap.
// RULE12 - Crystal writable bits: hysteresis, double bias, double gain; reset 00100.
// RULE13 - Force bit clear leaves state machine enable; set asserts the enable.
`timescale 1ns/1ps
`default_nettype none
`include "rot_map.svh"

module rot_regs
	import rot_pkg::*;
#(
	parameter int COEF_ENTRIES = 16,
	parameter int COEF_WIDTH   = 6
)
(
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  sys_rst,
	// Register access from the serial front end
	input  wire rot_reg_req_type       reg_req,
	output logic [7:0]                 reg_rdata,
	output logic                       reg_rvalid,
	// Power state machine side
	input  wire logic [2:0]            pwr_state,
	input  wire rot_blk_en_type        sm_blk_en,
	input  wire logic                  sm_xtal_buf_en,
	// RC oscillator calibration engine
	input  wire logic [6:0]            rc_coarse_int,
	output logic [6:0]                 rc_coarse_used,
	// Receive channel filter lookup
	input  wire logic [3:0]            coef_rd_idx,
	output logic [COEF_WIDTH-1:0]      coef_rd_data,
	// Analog controls
	output rot_blk_en_type             blk_en,
	output rot_xtal_type               xtal_ctrl
);

	// ************************************************************
	// Storage
	// ************************************************************
	logic [7:0]            force_a_q;
	logic [7:0]            force_b_q;
	logic [7:0]            force_c_q;
	logic [7:0]            coef_idx_q;
	logic [4:0]            xtal_wr_q;
	logic [7:0]            rc_q;
	logic [COEF_WIDTH-1:0] coef_mem [COEF_ENTRIES];
	logic [7:0]            rdata_d;
	logic [3:0]            sel_idx;
	rot_blk_en_type        blk_en_d;

	assign sel_idx = coef_idx_q[`ROT_COEF_IDX_MSB:0]; // Upper nibble is ignored [RULE6]

	// Force registers
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			force_a_q <= `ROT_RST_FORCE_A; // [RULE9]
			force_b_q <= `ROT_RST_FORCE_B;
			force_c_q <= `ROT_RST_FORCE_C; // [RULE11]
		end
		else if (reg_req.wr)
		begin
			if (reg_req.addr == `ROT_ADDR_FORCE_A)
				force_a_q <= reg_req.wdata;
			if (reg_req.addr == `ROT_ADDR_FORCE_B)
				force_b_q <= reg_req.wdata;
			if (reg_req.addr == `ROT_ADDR_FORCE_C)
				force_c_q <= reg_req.wdata;
		end
	end

	// Coefficient index; reserved bits are kept so they read back as written
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			coef_idx_q <= `ROT_RST_COEF_IDX;
		else if (reg_req.wr && reg_req.addr == `ROT_ADDR_COEF_IDX)
			coef_idx_q <= reg_req.wdata; // [RULE6]
	end

	// Coefficient table, one entry per index, cleared on reset
	generate
		for (genvar i = 0; i < COEF_ENTRIES; i++)
		begin : g_coef
			always_ff @(posedge sys_clk)
			begin
				if (sys_rst)
					coef_mem[i] <= COEF_WIDTH'(`ROT_RST_COEF_WORD); // [RULE7]
				else if (reg_req.wr && reg_req.addr == `ROT_ADDR_COEF_WORD
						&& sel_idx == 4'(i))
					coef_mem[i] <= reg_req.wdata[COEF_WIDTH-1:0]; // [RULE7]
			end
		end
	endgenerate

	// Crystal writable bits
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			xtal_wr_q <= `ROT_RST_XTAL_WR; // Only double gain set [RULE12]
		else if (reg_req.wr && reg_req.addr == `ROT_ADDR_XTAL)
			xtal_wr_q <= reg_req.wdata[`ROT_XTAL_WR_MSB:0]; // [RULE12]
	end

	// Coarse RC override register
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			rc_q <= `ROT_RST_RC_COARSE;
		else if (reg_req.wr && reg_req.addr == `ROT_ADDR_RC_COARSE)
			rc_q <= reg_req.wdata; // [RULE5]
	end

	// ************************************************************
	// Read path
	// ************************************************************
	always_comb
	begin
		rdata_d = `ROT_RDATA_ZERO; // Unmapped offsets read zero
		unique case (reg_req.addr)
			`ROT_ADDR_FORCE_A:   rdata_d = force_a_q;
			`ROT_ADDR_FORCE_B:   rdata_d = force_b_q;
			`ROT_ADDR_FORCE_C:   rdata_d = force_c_q;
			`ROT_ADDR_COEF_IDX:  rdata_d = coef_idx_q;
			`ROT_ADDR_COEF_WORD: rdata_d = 8'(coef_mem[sel_idx]); // Top bits zero [RULE7]
			`ROT_ADDR_XTAL:      rdata_d = {pwr_state, xtal_wr_q}; // [RULE1]
			`ROT_ADDR_RC_COARSE:
				// Live calibration result unless the host has taken over
				rdata_d = rc_q[`ROT_RC_OVR_BIT] ? rc_q
					: {1'h0, rc_coarse_int}; // [RULE4] [RULE5]
			default:             rdata_d = `ROT_RDATA_ZERO;
		endcase
	end

	// Read data registered; one cycle latency keeps outputs flop-driven
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			reg_rdata  <= `ROT_RDATA_ZERO;
			reg_rvalid <= 1'h0;
		end
		else
		begin
			reg_rvalid <= reg_req.rd;
			if (reg_req.rd)
				reg_rdata <= rdata_d;
		end
	end

	// ************************************************************
	// Analog control outputs
	// ************************************************************
	// Force bits can only turn blocks on, except lock detect bit 6 of b which follows its force bit alone; the state machine keeps them otherwise
	always_comb
	begin
		blk_en_d.a = sm_blk_en.a | force_a_q; // [RULE9] [RULE13]
		blk_en_d.b = sm_blk_en.b | force_b_q; // [RULE10] [RULE13]
		blk_en_d.b[`ROT_LDET_BIT] = force_b_q[`ROT_LDET_BIT]; // Direct drive [RULE8]
		blk_en_d.c = sm_blk_en.c | force_c_q; // [RULE11] [RULE13]
	end

	// Enable outputs
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			blk_en <= '0;
		else
			blk_en <= blk_en_d;
	end

	// Crystal controls; buffer enable bit is ignored until override is set
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			xtal_ctrl <= '0;
		else
		begin
			xtal_ctrl.hyst        <= xtal_wr_q[`ROT_XTAL_HYST_BIT]; // [RULE12]
			xtal_ctrl.double_bias <= xtal_wr_q[`ROT_XTAL_BIAS_BIT];
			xtal_ctrl.double_gain <= xtal_wr_q[`ROT_XTAL_GAIN_BIT];
			xtal_ctrl.buf_en      <= xtal_wr_q[`ROT_XTAL_OVR_BIT]
				? xtal_wr_q[`ROT_XTAL_BUF_BIT] : sm_xtal_buf_en; // [RULE2] [RULE3]
		end
	end

	// Calibration value used by the RC oscillator
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			rc_coarse_used <= '0;
		else
			rc_coarse_used <= rc_q[`ROT_RC_OVR_BIT]
				? rc_q[`ROT_RC_VAL_MSB:0] : rc_coarse_int; // [RULE4] [RULE5]
	end

	// Filter entry for the receive path
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			coef_rd_data <= '0;
		else
			coef_rd_data <= coef_mem[coef_rd_idx]; // [RULE6]
	end

endmodule : rot_regs

`default_nettype wire

// File: sim/rot_regs_assertions.sv
// Port checker of the radio test bank
`timescale 1ns/1ps
`default_nettype none
module rot_regs_assertions
	import rot_pkg::*;
(
	// Clock and reset
	input wire logic            sys_clk,
	input wire logic            sys_rst,
	// Watched ports
	input wire rot_reg_req_type reg_req,
	input wire logic [7:0]      reg_rdata,
	input wire logic [2:0]      pwr_state,
	input wire rot_blk_en_type  sm_blk_en,
	input wire logic            sm_xtal_buf_en,
	input wire logic [6:0]      rc_coarse_int,
	input wire logic [6:0]      rc_coarse_used,
	input wire rot_blk_en_type  blk_en,
	input wire rot_xtal_type    xtal_ctrl
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// Decoded strobes
	wire logic rd61 = reg_req.rd && reg_req.addr == 7'h61;
	wire logic rd62 = reg_req.rd && reg_req.addr == 7'h62;
	wire logic rd63 = reg_req.rd && reg_req.addr == 7'h63;
	wire logic wr5d = reg_req.wr && reg_req.addr == 7'h5D;
	wire logic wr5e = reg_req.wr && reg_req.addr == 7'h5E;
	pwr_read_a: assert property (rd62 |=> reg_rdata[7:5] == $past(pwr_state))
		else $error("power state read wrong");
	buf_sel_a: assert property (rd62 |=> xtal_ctrl.buf_en ==
		(reg_rdata[1] ? reg_rdata[0] : $past(sm_xtal_buf_en))) else $error("buffer enable wrong");
	xtal_bits_a: assert property (rd62 |=> reg_rdata[4:2] ==
		{xtal_ctrl.hyst, xtal_ctrl.double_bias, xtal_ctrl.double_gain}) else $error("xtal bits");
	rc_used_a: assert property (rd63 |=> rc_coarse_used ==
		(reg_rdata[7] ? reg_rdata[6:0] : $past(rc_coarse_int))) else $error("rc used wrong");
	rc_view_a: assert property (rd63 |=> reg_rdata[7] ||
		reg_rdata[6:0] == $past(rc_coarse_int)) else $error("rc view wrong");
	// Reset edge is skipped since the enables clear while the inputs run on
	sm_pass_a: assert property (!$past(sys_rst) |->
		(~blk_en & $past(sm_blk_en) & 24'hFFBFFF) == 24'h0) else $error("enable lost");
	ldet_direct_a: assert property (wr5e |=> ##1
		blk_en.b[6] == $past(reg_req.wdata[6], 2)) else $error("lock detect wrong");
	force_a_a: assert property (wr5d |=> ##1
		(blk_en.a & $past(reg_req.wdata, 2)) == $past(reg_req.wdata, 2)) else $error("force a");
	coef_rsv_a: assert property (rd61 |=> reg_rdata[7:6] == 2'h0)
		else $error("reserved bits set");
	cover property (rd63 ##1 reg_rdata[7]);
	cover property (rd62 ##1 reg_rdata[1]);
	cover property (wr5e ##1 1'h1 ##1 blk_en.b[6]);
endmodule : rot_regs_assertions
bind rot_regs rot_regs_assertions u_chk (.sys_clk, .sys_rst, .reg_req, .reg_rdata, .pwr_state,
	.sm_blk_en, .sm_xtal_buf_en, .rc_coarse_int, .rc_coarse_used, .blk_en, .xtal_ctrl);
`default_nettype wire

// File: sim/rot_host_model.sv
// Host side model issuing single register accesses
`timescale 1ns/1ps
`default_nettype none
module rot_host_model
	import rot_pkg::*;
(
	// Clock
	input wire logic        sys_clk,
	// Register requests
	output rot_reg_req_type reg_req
);
	initial reg_req = '0;
	// One strobe cycle; idle bus shows inverted values so stale ones never match
	task automatic put(input logic w, input logic [6:0] a, input logic [7:0] d);
		@(posedge sys_clk) #1 reg_req = {w, !w, a, d};
		@(posedge sys_clk) #1 reg_req = {1'h0, 1'h0, ~a, ~d};
	endtask : put
endmodule : rot_host_model
`default_nettype wire

// File: sim/rot_regs_tb_top.sv
// Self-checking bench of the radio test bank
`timescale 1ns/1ps
`default_nettype none
module rot_regs_tb_top;
	import rot_pkg::*;
	logic            sys_clk = 1'h0;
	logic            sys_rst = 1'h1;
	rot_reg_req_type req;
	logic [7:0]      rdat, d, e;
	logic [31:0]     r;
	logic [23:0]     f;
	logic            rvl, smb = 1'h0;
	logic [2:0]      pw = 3'h0;
	logic [2:0]      pws [5] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h7};
	rot_blk_en_type  sm = '0, be;
	logic [6:0]      rci = 7'h0, rcu;
	logic [3:0]      ci = 4'h0;
	logic [5:0]      cd, tbl [16];
	rot_xtal_type    xc;
	int              n_mismatch = 0, checks = 0, seed = 32'h9A399BD9;
	always #25 sys_clk = ~sys_clk;
	rot_regs u_dut (.sys_clk, .sys_rst, .reg_req(req), .reg_rdata(rdat), .reg_rvalid(rvl),
		.pwr_state(pw), .sm_blk_en(sm), .sm_xtal_buf_en(smb), .rc_coarse_int(rci),
		.rc_coarse_used(rcu), .coef_rd_idx(ci), .coef_rd_data(cd), .blk_en(be), .xtal_ctrl(xc));
	rot_host_model u_host (.sys_clk, .reg_req(req));
	task automatic chk(input string n, input logic [23:0] x, input logic [23:0] g);
		checks++;
		if (x !== g)
		begin
			n_mismatch++;
			$display("[ERR] %s exp %h got %h", n, x, g);
		end
	endtask : chk
	// Expected coarse RC read: stored byte under override, live result otherwise
	function automatic logic [7:0] exp_rc(input logic [7:0] w, input logic [6:0] cal);
		return w[7] ? w : {1'h0, cal};
	endfunction : exp_rc
	// Expected enables: state machine or force, lock detect from its force bit alone
	function automatic logic [23:0] exp_blk(input logic [23:0] s, input logic [23:0] frc);
		return (s & 24'hFFBFFF) | frc;
	endfunction : exp_blk
	task automatic wr(input logic [6:0] a, input logic [7:0] v);
		u_host.put(1'h1, a, v);
	endtask : wr
	// Answer is registered, so it is settled just after the edge that ends the strobe
	task automatic rd(input logic [6:0] a, output logic [7:0] v);
		u_host.put(1'h0, a, 8'h00);
		chk("rvalid", 24'h1, rvl);
		v = rdat;
	endtask : rd
	task automatic end_of_test;
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_of_test
	// Watchdog far beyond the roughly 700 cycles the run needs
	initial
	begin
		#1000000;
		n_mismatch++;
		end_of_test();
	end
	// Main sequence
	initial
	begin
		repeat (5) @(posedge sys_clk);
		#1 sys_rst = 1'h0;
		rci = 7'h55;
		for (int a = 'h5D; a <= 'h63; a++)
		begin
			rd(a[6:0], d);
			chk("reset", a == 'h62 ? 8'h04 : a == 'h63 ? 8'h55 : 8'h00, d);
		end
		foreach (pws[i])
		begin
			pw = pws[i];
			rd(7'h62, d);
			chk("pwr", {pws[i], 5'h04}, d);
		end
		repeat (24)
		begin
			r = $random(seed);
			sm = r[23:0];
			smb = r[31];
			rci = r[30:24];
			r = $random(seed);
			e = r[7:0];
			f = r[31:8];
			for (int k = 0; k < 3; k++)
				wr(7'h5D + k[6:0], f[23 - 8 * k -: 8]);
			for (int k = 0; k < 3; k++)
			begin
				rd(7'h5D + k[6:0], d);
				chk("force", f[23 - 8 * k -: 8], d);
			end
			chk("blk_en", exp_blk(sm, f), be);
			wr(7'h62, e);
			rd(7'h62, d);
			chk("xtal", {pw, e[4:0]}, d);
			chk("xbuf", e[1] ? e[0] : smb, xc.buf_en);
			chk("xbits", e[4:2], {xc.hyst, xc.double_bias, xc.double_gain});
			wr(7'h63, ~e);
			rd(7'h63, d);
			chk("rc", exp_rc(~e, rci), d);
			chk("rc_used", exp_rc(~e, rci) & 8'h7F, rcu);
		end
		for (int i = 0; i < 16; i++)
		begin
			r = $random(seed);
			tbl[i] = r[5:0];
			wr(7'h60, {r[11:8], i[3:0]});
			wr(7'h61, {r[7:0]});
		end
		for (int i = 15; i >= 0; i--)
		begin
			wr(7'h60, i[7:0]);
			rd(7'h60, d);
			chk("coef_idx", i, d);
			rd(7'h61, d);
			chk("coef", {2'h0, tbl[i]}, d);
			ci = i[3:0];
			@(posedge sys_clk) #1 chk("coef_rd", tbl[i], cd);
		end
		// Mid-run reset must clear table entry 0 and the first force register again
		@(posedge sys_clk) #1 sys_rst = 1'h1;
		repeat (2) @(posedge sys_clk);
		#1 sys_rst = 1'h0;
		rd(7'h61, d);
		chk("coef_rst", 24'h0, d);
		rd(7'h5D, d);
		chk("force_rst", 24'h0, d);
		rd(7'h62, d);
		chk("xtal_rst", {pw, 5'h04}, d);
		wr(7'h70, 8'hFF);
		rd(7'h70, d);
		chk("unmapped", 24'h0, d);
		end_of_test();
	end
endmodule : rot_regs_tb_top
`default_nettype wire
